/* inc/line_if_regs.svh */
// Register, command and timing constants of the host serial control port
`ifndef LINE_IF_REGS_SVH
`define LINE_IF_REGS_SVH

// Command byte layout, first bit on the wire is bit 0
`define CMD_RW_BIT          0
`define CMD_ADDR_LSB        1
`define CMD_ADDR_MSB        6
`define CMD_RW_READ         1'h1
`define LINE_CONTROL_ADDR   6'h10

// Write data fields of line_control
`define CTL_LOST_CLR        0
`define CTL_FAULT_CLR       1
`define CTL_LEN_LSB         2
`define CTL_LEN_MSB         4
`define CTL_FAR             5
`define CTL_NEAR            6
`define CTL_ONES            7

// Status codes for line_status bits 5..7, written {b5,b6,b7}
`define CODE_FAR            3'h4
`define CODE_CHANGED        1'h1

// Rising edge counts within a transfer
`define CNT_ZERO            5'h00
`define CNT_ONE             5'h01
`define CNT_CMD_DONE        5'h08
`define CNT_WRITE_DONE      5'h10
`define CNT_LIMIT           5'h11
// edge_select = 1: bits launch on falling edges after rises 8..15, off after rise 16
`define RD_FIRST_E1         5'h08
`define RD_END_E1           5'h10
// edge_select = 0: bits launch on rises 9..16, off at rise 17
`define RD_FIRST_E0         5'h09
`define RD_END_E0           5'h11

// Synchroniser lane assignment
`define SYNC_LANES          9
`define SYNC_SEL            0
`define SYNC_CLK            1
`define SYNC_DIN            2
`define SYNC_EDGE           3
`define SYNC_LOST           4
`define SYNC_FAULT          5
`define SYNC_RCLK           6
`define SYNC_RXP            7
`define SYNC_RXN            8

`endif

/* inc/line_if_pkg.sv */
// Types shared by the host serial control port design
package line_if_pkg;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } sync_state_t;

    typedef enum logic [1:0] {
        phase_wait = 2'b00,
        phase_idle = 2'b01,
        phase_cmd  = 2'b10,
        phase_data = 2'b11
    } port_phase_t;

    typedef struct packed {
        logic [2:0] line_length;
        logic       far_loopback;
        logic       near_loopback;
        logic       send_all_ones;
        logic       device_reset;
    } line_ctrl_t;

    typedef struct packed {
        port_phase_t phase;
        logic [4:0]  rise_cnt;
        logic [7:0]  cmd_sr;
        logic [7:0]  data_sr;
        logic        is_read;
        logic        matched;
        logic [7:0]  out_sr;
        logic        out_bit;
        logic        out_en;
        line_ctrl_t  ctrl;
        logic        lost_mask;
        logic        fault_mask;
        logic        lost_changed;
        logic        fault_changed;
        logic        alarm_en;
        logic        rx_plus;
        logic        rx_minus;
    } port_state_t;

endpackage

/* hw/edge_sync.sv */
// Two-stage synchroniser with edge detection for one pin
`timescale 1ns/100ps

module edge_sync (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic reset_n,
    // Pin side
    input  wire logic pin,
    // Synchronised side
    output logic      level,
    output logic      rise,
    output logic      fall
);

    line_if_pkg::sync_state_t st_reg;
    line_if_pkg::sync_state_t st_next;

    always_comb begin
        st_next    = st_reg;
        st_next.s1 = pin;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Only the second and third stages are looked at; s1 may be metastable
    assign level = st_reg.s2;
    assign rise  = st_reg.s2 & ~st_reg.s3;
    assign fall  = ~st_reg.s2 & st_reg.s3;

endmodule

/* hw/line_if_host_serial_port.sv */
// Host-mode serial control port of a line interface: command decode, register, status and alarm
`timescale 1ns/100ps
`include "line_if_regs.svh"

module line_if_host_serial_port (
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    reset_n,
    // Serial control port pins
    input  wire logic                    select_n,
    input  wire logic                    port_clock,
    input  wire logic                    port_in,
    output logic                         port_out,
    output logic                         port_out_oe,
    input  wire logic                    edge_select,
    // Open-drain alarm, pin pulled low while enable is high
    output logic                         alarm_oe,
    // Line status from the detectors
    input  wire logic                    signal_lost,
    input  wire logic                    driver_fault,
    // Receive data retiming
    input  wire logic                    recovered_clock,
    input  wire logic                    rx_plus_in,
    input  wire logic                    rx_minus_in,
    output logic                         rx_plus,
    output logic                         rx_minus,
    // Control to the line datapath
    output line_if_pkg::line_ctrl_t      line_ctrl
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [`SYNC_LANES-1:0] pins;
    logic [`SYNC_LANES-1:0] lvl;
    logic [`SYNC_LANES-1:0] rise;
    logic [`SYNC_LANES-1:0] fall;

    assign pins[`SYNC_SEL]   = select_n;
    assign pins[`SYNC_CLK]   = port_clock;
    assign pins[`SYNC_DIN]   = port_in;
    assign pins[`SYNC_EDGE]  = edge_select;
    assign pins[`SYNC_LOST]  = signal_lost;
    assign pins[`SYNC_FAULT] = driver_fault;
    assign pins[`SYNC_RCLK]  = recovered_clock;
    assign pins[`SYNC_RXP]   = rx_plus_in;
    assign pins[`SYNC_RXN]   = rx_minus_in;

    // Data and clock share the same latency, so a sampled bit lines up with its edge
    for (genvar i = 0; i < `SYNC_LANES; i++) begin : g_sync
        edge_sync u_sync (
            .sys_clk (sys_clk),
            .reset_n (reset_n),
            .pin     (pins[i]),
            .level   (lvl[i]),
            .rise    (rise[i]),
            .fall    (fall[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // State

    line_if_pkg::port_state_t st_reg;
    line_if_pkg::port_state_t st_next;

    logic       sel_high;
    logic       clk_rise;
    logic       clk_fall;
    logic       din;
    logic       edge_hi;
    logic [4:0] cnt_inc;
    logic [7:0] cmd_full;
    logic [7:0] wr_data;
    logic [7:0] status_now;
    logic [2:0] code_now;

    assign sel_high = lvl[`SYNC_SEL];
    assign clk_rise = rise[`SYNC_CLK];
    assign clk_fall = fall[`SYNC_CLK];
    assign din      = lvl[`SYNC_DIN];
    assign edge_hi  = lvl[`SYNC_EDGE];

    // Extra clocks past the end of a transfer saturate and change nothing
    assign cnt_inc  = (st_reg.rise_cnt == `CNT_LIMIT) ? st_reg.rise_cnt : st_reg.rise_cnt + `CNT_ONE;
    assign cmd_full = {din, st_reg.cmd_sr[7:1]};
    assign wr_data  = {din, st_reg.data_sr[7:1]};

    ////////////////////////////////////////////////////////////////////////////
    // Status byte

    always_comb begin
        // Change flags outrank the loopback codes; far loopback outranks the rest
        if (st_reg.lost_changed | st_reg.fault_changed) begin
            code_now = {`CODE_CHANGED, st_reg.lost_changed, st_reg.fault_changed};
        end else if (st_reg.ctrl.far_loopback) begin
            code_now = `CODE_FAR;
        end else begin
            code_now = {1'h0, st_reg.ctrl.near_loopback, st_reg.ctrl.send_all_ones};
        end
        status_now = {code_now[0], code_now[1], code_now[2], st_reg.ctrl.line_length,
                      lvl[`SYNC_FAULT], lvl[`SYNC_LOST]};
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_next                   = st_reg;
        st_next.ctrl.device_reset = 1'h0;

        if (sel_high) begin
            // Select high ends any transfer at once and floats the output
            st_next.phase    = line_if_pkg::phase_idle;
            st_next.rise_cnt = `CNT_ZERO;
            st_next.out_en   = 1'h0;
        end else begin
            case (st_reg.phase)
                line_if_pkg::phase_wait: begin
                    // Select low without a prior high: not a transfer
                    st_next.out_en = 1'h0;
                end
                line_if_pkg::phase_idle: begin
                    // Clock level at this point does not matter; only rises count
                    st_next.phase    = line_if_pkg::phase_cmd;
                    st_next.rise_cnt = `CNT_ZERO;
                    st_next.matched  = 1'h0;
                    st_next.is_read  = 1'h0;
                    st_next.out_en   = 1'h0;
                end
                line_if_pkg::phase_cmd: begin
                    if (clk_rise) begin
                        st_next.cmd_sr   = cmd_full;
                        st_next.rise_cnt = cnt_inc;
                        if (cnt_inc == `CNT_CMD_DONE) begin
                            st_next.phase   = line_if_pkg::phase_data;
                            st_next.is_read = (cmd_full[`CMD_RW_BIT] == `CMD_RW_READ);
                            // Bit 7 takes no part in the match
                            st_next.matched = (cmd_full[`CMD_ADDR_MSB:`CMD_ADDR_LSB]
                                               == `LINE_CONTROL_ADDR);
                            // Snapshot so the byte stays coherent while it shifts out
                            st_next.out_sr  = status_now;
                        end
                    end
                end
                line_if_pkg::phase_data: begin
                    if (clk_rise) begin
                        st_next.rise_cnt = cnt_inc;
                        if (st_reg.rise_cnt < `CNT_WRITE_DONE) begin
                            st_next.data_sr = wr_data;
                        end
                        if (!edge_hi && st_reg.is_read && st_reg.matched) begin
                            if (cnt_inc >= `RD_FIRST_E0 && cnt_inc < `RD_END_E0) begin
                                st_next.out_bit = st_reg.out_sr[3'(cnt_inc - `RD_FIRST_E0)];
                                st_next.out_en  = 1'h1;
                            end else if (cnt_inc == `RD_END_E0) begin
                                st_next.out_en = 1'h0;
                            end
                        end
                        if (edge_hi && cnt_inc == `RD_END_E1) begin
                            st_next.out_en = st_reg.out_en;
                        end
                    end
                    if (clk_fall && edge_hi && st_reg.is_read && st_reg.matched) begin
                        if (st_reg.rise_cnt >= `RD_FIRST_E1 && st_reg.rise_cnt < `RD_END_E1) begin
                            st_next.out_bit = st_reg.out_sr[3'(st_reg.rise_cnt - `RD_FIRST_E1)];
                            st_next.out_en  = 1'h1;
                        end else if (st_reg.rise_cnt >= `RD_END_E1) begin
                            st_next.out_en = 1'h0;
                        end
                    end
                    // A write or an unmatched command never drives the pin
                    if (!(st_reg.is_read && st_reg.matched)) begin
                        st_next.out_en = 1'h0;
                    end
                end
                default: begin
                    st_next.phase = line_if_pkg::phase_wait;
                end
            endcase
        end

        // Register write on the rise that brings in the last data bit
        if (!sel_high && st_reg.phase == line_if_pkg::phase_data && clk_rise
            && cnt_inc == `CNT_WRITE_DONE && st_reg.rise_cnt != `CNT_WRITE_DONE
            && !st_reg.is_read && st_reg.matched) begin
            if (wr_data[`CTL_FAR] && wr_data[`CTL_NEAR]) begin
                st_next.ctrl          = '0;
                st_next.ctrl.device_reset = 1'h1;
                st_next.lost_mask     = 1'h0;
                st_next.fault_mask    = 1'h0;
                st_next.lost_changed  = 1'h0;
                st_next.fault_changed = 1'h0;
            end else begin
                st_next.ctrl.line_length   = wr_data[`CTL_LEN_MSB:`CTL_LEN_LSB];
                st_next.ctrl.far_loopback  = wr_data[`CTL_FAR];
                st_next.ctrl.near_loopback = wr_data[`CTL_NEAR];
                st_next.ctrl.send_all_ones = wr_data[`CTL_ONES];
                // 1 masks and clears the source, 0 re-enables it
                st_next.lost_mask  = wr_data[`CTL_LOST_CLR];
                st_next.fault_mask = wr_data[`CTL_FAULT_CLR];
                if (wr_data[`CTL_LOST_CLR]) begin
                    st_next.lost_changed = 1'h0;
                end
                if (wr_data[`CTL_FAULT_CLR]) begin
                    st_next.fault_changed = 1'h0;
                end
            end
        end

        // Status changes set after the write, so an edge in the clear cycle survives
        if ((rise[`SYNC_LOST] | fall[`SYNC_LOST]) && !st_reg.lost_mask) begin
            st_next.lost_changed = 1'h1;
        end
        if ((rise[`SYNC_FAULT] | fall[`SYNC_FAULT]) && !st_reg.fault_mask) begin
            st_next.fault_changed = 1'h1;
        end

        // Reads touch nothing here, so a pending alarm stays until a clear write
        st_next.alarm_en = st_next.lost_changed | st_next.fault_changed;

        // Receive retiming on the recovered clock, independent of the port clock
        if ((edge_hi && rise[`SYNC_RCLK]) || (!edge_hi && fall[`SYNC_RCLK])) begin
            st_next.rx_plus  = lvl[`SYNC_RXP];
            st_next.rx_minus = lvl[`SYNC_RXN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Registers run on sys_clk only; every pin, recovered_clock included, is seen through its synchroniser
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign port_out    = st_reg.out_bit;
    assign port_out_oe = st_reg.out_en;
    assign alarm_oe    = st_reg.alarm_en;
    assign rx_plus     = st_reg.rx_plus;
    assign rx_minus    = st_reg.rx_minus;
    assign line_ctrl   = st_reg.ctrl;

endmodule

/* tb/line_if_checker.sv */
// Assertions on the pins of the host serial control port
`timescale 1ns/100ps

module line_if_checker (
    // Clock and reset
    input wire logic                    sys_clk,
    input wire logic                    reset_n,
    // Serial port
    input wire logic                    select_n,
    input wire logic                    port_clock,
    input wire logic                    port_out,
    input wire logic                    port_out_oe,
    input wire logic                    edge_select,
    // Status and control
    input wire logic                    alarm_oe,
    input wire logic                    signal_lost,
    input wire logic                    driver_fault,
    input wire line_if_pkg::line_ctrl_t line_ctrl
);
    logic [2:0] prev;
    logic [3:0] since_evt;
    logic [3:0] since_rise;
    logic [3:0] since_fall;

    function automatic logic [3:0] bump(input logic [3:0] c);
        return c + {3'h0, c != 4'hf};
    endfunction

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    ////////////////////////////////////////////////////////////////////////////////
    // Ages of pin events; saturating so an old edge never wraps back to look fresh
    always_ff @(posedge sys_clk) begin
        prev <= {signal_lost, driver_fault, port_clock};
        if (!reset_n) begin
            since_evt  <= 4'h0;
            since_rise <= 4'hf;
            since_fall <= 4'hf;
        end else begin
            since_evt  <= (prev[2:1] != {signal_lost, driver_fault}) ? 4'h0 : bump(since_evt);
            since_rise <= (port_clock && !prev[0]) ? 4'h0 : bump(since_rise);
            since_fall <= (!port_clock && prev[0]) ? 4'h0 : bump(since_fall);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    reset_clears_a: assert property ($rose(reset_n) |-> !port_out_oe && !alarm_oe && line_ctrl == 7'h00)
        else $error("outputs not cleared by reset");
    oe_select_off_a: assert property (select_n [*5] |-> !port_out_oe)
        else $error("port_out enabled while deselected");
    oe_rise_sel_a: assert property ($rose(port_out_oe) |-> !select_n && !$past(select_n, 4))
        else $error("port_out enabled outside a transfer");
    dout_edge_a: assert property (port_out_oe && $past(port_out_oe) && $changed(port_out)
        |-> (edge_select ? since_fall : since_rise) <= 4'h5) else $error("port_out moved off its edge");
    oe_edge_a: assert property ($fell(port_out_oe) && !select_n && $past(reset_n)
        |-> (edge_select ? since_fall : since_rise) <= 4'h5) else $error("last bit hold ended off its edge");
    alarm_cause_a: assert property ($rose(alarm_oe) |-> since_evt <= 4'h8)
        else $error("alarm without a status change");
    alarm_hold_a: assert property ($fell(alarm_oe) && $past(reset_n) |-> !$past(select_n, 4))
        else $error("alarm released without a write");
    reset_pulse_a: assert property (line_ctrl.device_reset |=> line_ctrl == 7'h00)
        else $error("device reset left control set");
    loop_excl_a: assert property (!(line_ctrl.far_loopback && line_ctrl.near_loopback))
        else $error("both loopbacks active");
    ctrl_idle_a: assert property (select_n [*8] |-> $stable(line_ctrl))
        else $error("control changed between transfers");
endmodule

bind line_if_host_serial_port line_if_checker i_checker (
    .sys_clk, .reset_n, .select_n, .port_clock, .port_out, .port_out_oe, .edge_select,
    .alarm_oe, .signal_lost, .driver_fault, .line_ctrl
);

/* tb/host_port_model.sv */
// Host controller model driving the serial control port
`timescale 1ns/100ps

module host_port_model (
    // Clock
    input wire logic sys_clk,
    // Serial port pins
    output logic     select_n,
    output logic     port_clock,
    output logic     port_in,
    input wire logic port_out,
    input wire logic port_out_oe,
    input wire logic edge_select
);
    // A released pin reads as the inverse of its last bit, so a float never passes for data
    logic            line_seen;

    assign line_seen = port_out_oe ? port_out : ~port_out;

    initial begin
        select_n = 1'h1;
        port_clock = 1'h0;
        port_in = 1'h0;
    end

    // Half of the 800 ns serial clock; pins move on falling sys_clk only
    task automatic half();
        repeat (4) @(negedge sys_clk);
    endtask

    // Bits are sampled just before the next launch, so up to 7 cycles of lag are tolerated
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] data, input logic idle_hi,
                        input int n, output logic [7:0] rd, output logic [8:0] map);
        logic [15:0] bits;
        bits = {data, cmd};
        rd = 8'h00;
        map = 9'h000;
        port_clock = idle_hi;
        half();
        select_n = 1'h0;
        half();
        for (int c = 0; c < n; c++) begin
            if (edge_select && c > 8) {map[c - 9], rd[c - 9]} = {port_out_oe, line_seen};
            port_clock = 1'h0;
            port_in = (c < 16) ? bits[c] : ~port_in;
            half();
            if (!edge_select && c > 8) {map[c - 9], rd[c - 9]} = {port_out_oe, line_seen};
            port_clock = 1'h1;
            half();
        end
        if (n == 17) begin
            half();
            map[8] = port_out_oe;
        end
        select_n = 1'h1;
        half();
        half();
        map[8] = map[8] | port_out_oe;
        port_in = ~port_in;
    endtask
endmodule

/* tb/tb.sv */
// Self-checking bench for the host serial control port
`timescale 1ns/100ps

module tb;
    logic                    sys_clk, reset_n, select_n, port_clock, port_in, port_out, port_out_oe;
    logic                    edge_select, alarm_oe, signal_lost, driver_fault, recovered_clock;
    logic                    rx_plus_in, rx_minus_in, rx_plus, rx_minus, idle_hi;
    line_if_pkg::line_ctrl_t line_ctrl;
    logic [7:0]              rd;
    logic [8:0]              map;
    logic [8:0]              pulses;
    int                      errors, checks, cycles;

    line_if_host_serial_port i_dut (
        .sys_clk, .reset_n, .select_n, .port_clock, .port_in, .port_out, .port_out_oe,
        .edge_select, .alarm_oe, .signal_lost, .driver_fault, .recovered_clock,
        .rx_plus_in, .rx_minus_in, .rx_plus, .rx_minus, .line_ctrl
    );
    host_port_model i_host (.sys_clk, .select_n, .port_clock, .port_in, .port_out, .port_out_oe, .edge_select);

    always #50 sys_clk = ~sys_clk;

    // Runs take about 6100 cycles; the ceiling leaves room without hiding a hang
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 12000) begin
            errors++;
            $display("unexpected %0t run timed out", $time);
            results();
        end
    end

    // Counts device reset pulses, so a request that clears without pulsing is caught
    always @(posedge sys_clk) begin
        if (!reset_n) begin
            pulses <= 9'h000;
        end else if (line_ctrl.device_reset) begin
            pulses <= pulses + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic xf(input logic [7:0] cmd, input logic [7:0] d, input int n);
        idle_hi = ~idle_hi;
        i_host.xfer(cmd, d, idle_hi, n, rd, map);
    endtask

    task automatic rdc(input logic [7:0] exp);
        xf(8'h21, 8'h00, 17);
        check(map, 9'h0ff);
        check(rd, exp);
    endtask

    // Flags f are lost, fault, lost changed, fault changed
    function automatic logic [7:0] status(input logic [7:0] ctl, input logic [3:0] f);
        logic [2:0] code;
        if (f[1] || f[0]) begin
            code = {1'h1, f[1:0]};
        end else if (ctl[5]) begin
            code = 3'h4;
        end else begin
            code = {1'h0, ctl[6], ctl[7]};
        end
        return {code[0], code[1], code[2], ctl[4:2], f[2], f[3]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check({alarm_oe, line_ctrl}, 8'h00);
        rdc(8'h00);
        $display("test reset done");
    endtask

    task automatic t_codes();
        logic [7:0] tbl [6];
        tbl = '{8'h23, 8'h47, 8'h8b, 8'hd3, 8'hbf, 8'h1b};
        for (int i = 0; i < 6; i++) begin
            edge_select = i[0];
            xf(i[1] ? 8'ha0 : 8'h20, tbl[i], 17);
            check(line_ctrl, {tbl[i][4:2], tbl[i][5], tbl[i][6], tbl[i][7], 1'h0});
            rdc(status(tbl[i], 4'h0));
        end
        $display("test codes done");
    endtask

    task automatic t_addr();
        for (int b = 1; b < 7; b++) begin
            xf(8'h20 ^ (8'h01 << b), 8'h9f, 17);
            xf(8'h21 ^ (8'h01 << b), 8'h00, 17);
            check(map, 9'h000);
        end
        check(line_ctrl, 7'h60);
        $display("test address done");
    endtask

    task automatic t_abort();
        for (int e = 0; e < 2; e++) begin
            edge_select = e[0];
            xf(8'h21, 8'h00, 12);
            check(map, 9'h007);
            rdc(8'h18);
        end
        $display("test abort done");
    endtask

    task automatic t_alarm();
        xf(8'h20, 8'h18, 17);
        signal_lost = 1'h1;
        wait_n(10);
        check(alarm_oe, 1'h1);
        rdc(status(8'h18, 4'ha));
        check(alarm_oe, 1'h1);
        driver_fault = 1'h1;
        wait_n(10);
        rdc(status(8'h18, 4'hf));
        xf(8'h20, 8'h19, 17);
        check(alarm_oe, 1'h1);
        rdc(status(8'h18, 4'hd));
        xf(8'h20, 8'h1b, 17);
        check(alarm_oe, 1'h0);
        signal_lost = 1'h0;
        wait_n(10);
        check(alarm_oe, 1'h0);
        rdc(status(8'h18, 4'h4));
        xf(8'h20, 8'h18, 17);
        driver_fault = 1'h0;
        wait_n(10);
        check(alarm_oe, 1'h1);
        check(pulses, 9'h000);
        xf(8'h20, 8'h60, 17);
        check({alarm_oe, line_ctrl}, 8'h00);
        check(pulses, 9'h001);
        rdc(8'h00);
        $display("test alarm done");
    endtask

    task automatic t_rx();
        rx_plus_in = 1'h1;
        wait_n(10);
        check({rx_plus, rx_minus}, 2'h0);
        recovered_clock = 1'h1;
        wait_n(10);
        check({rx_plus, rx_minus}, 2'h2);
        edge_select = 1'h0;
        {rx_plus_in, rx_minus_in} = 2'h1;
        wait_n(10);
        check({rx_plus, rx_minus}, 2'h2);
        recovered_clock = 1'h0;
        wait_n(10);
        check({rx_plus, rx_minus}, 2'h1);
        $display("test receive done");
    endtask

    initial begin
        {sys_clk, reset_n, idle_hi, signal_lost, driver_fault} = 5'h00;
        {edge_select, recovered_clock, rx_plus_in, rx_minus_in} = 4'h8;
        {errors, checks, cycles} = '0;
        repeat (12) @(negedge sys_clk);
        reset_n = 1'h1;
        wait_n(8);
        t_reset();
        t_codes();
        t_addr();
        t_abort();
        t_alarm();
        t_rx();
        results();
    end
endmodule
